//--- shared/adc_regs_pkg.sv
// Purpose: Constants for the converter status/config/range register bank
// Assumes: AHB-Lite word access, byte address is four times the index
// Notes:   Register widths are 8 bits in the low byte of each word, 3 bits for the interrupt status and mask
//
// Summary of operation
// - Bit 7 of the flags register is set while a reset of the regulator is seen.
// - Bit 6 of the flags register is set while any digital error is present.
// - Bit 5 of the flags register is set while an open analog input is seen.
// - The flags register at index 0x01 is read-only and resets to 0x00.
// - Setup bit 6 enables the status byte header on conversion results.
// - Setup bit 5 makes the convert-start pin clock the oversampling.
// - Setup bits 4:3 pick one, two, four or eight serial output lines.
// - Setup bits 1:0 pick normal, standby, auto standby or shutdown.
// - The setup register at index 0x02 resets to 0x08, bits 7 and 2 read zero.
// - Range codes 0000 to 1011 select the documented input spans.
// - Index 0x03 bits 7:4 hold the channel 2 range, read and write.
// - Index 0x03 bits 3:0 hold the channel 1 range, read and write.
// - The channel 1/2 range register resets to 0x33.
// - Index 0x04 holds channel 4 in bits 7:4, channel 3 in 3:0, reset 0x33.
package adc_regs_pkg;
  // Register indices, byte address is index * 4
  localparam logic [7:0] IDX_FLAGS     = 8'h01;
  localparam logic [7:0] IDX_SETUP     = 8'h02;
  localparam logic [7:0] IDX_SPAN12    = 8'h03;
  localparam logic [7:0] IDX_SPAN34    = 8'h04;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h08;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h09;
  // Reset values
  localparam logic [7:0] FLAGS_RST     = 8'h00;
  localparam logic [7:0] SETUP_RST     = 8'h08;
  localparam logic [7:0] SPAN_RST      = 8'h33;
  localparam logic [2:0] IRQ_RST       = 3'h0;
  // Flag and setup field positions
  localparam int         FLG_RESET     = 7;
  localparam int         FLG_LOGIC     = 6;
  localparam int         FLG_OPEN      = 5;
  localparam int         SET_HEADER    = 6;
  localparam int         SET_EXT_CLK   = 5;
  localparam int         SET_LINES_HI  = 4;
  localparam int         SET_LINES_LO  = 3;
  localparam int         SET_MODE_HI   = 1;
  localparam int         SET_MODE_LO   = 0;
  localparam logic [7:0] SETUP_WMASK   = 8'h7B;
  // Range codes above this one are undefined
  localparam logic [3:0] SPAN_MAX      = 4'hB;
  localparam int         SPAN_W        = 4;
  localparam int         SPAN_CNT      = 4;
  // AHB encodings
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic [1:0] HTRANS_NSEQ   = 2'h2;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'h0,
    MODE_STANDBY  = 2'h1,
    MODE_AUTO_SBY = 2'h2,
    MODE_SHUTDOWN = 2'h3
  } op_mode_e;
  // Bus slave states, Gray along the read path
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_LOAD = 2'h1,
    BUS_OUT  = 2'h3
  } bus_state_e;
endpackage

//--- logic/adc_status_config_regs.sv
// Purpose: Flags, setup and channel 1-4 range registers over AHB-Lite
// Assumes: Single word transfers; diagnostic sources synchronous to hclk
// Notes:   Reads take one wait state, writes none; hresp is always OKAY
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
module adc_status_config_regs
  import adc_regs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                ce,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Diagnostic sources
  input  wire logic                reset_seen,
  input  wire logic                logic_fault_present,
  input  wire logic                open_circuit_present,
  input  wire logic [7:0]          logic_fault_detail_reg,
  // Oversampling trigger
  input  wire logic                convert_start_pin,
  input  wire logic                internal_os_clk,
  output logic                     os_conv_trigger,
  // Setup outputs
  output logic                     status_header_en,
  output logic [7:0]               status_header_byte,
  output logic                     outside_oversample_clk_en,
  output logic [1:0]               serial_out_line_sel,
  output adc_regs_pkg::op_mode_e   op_mode,
  // Range selectors
  output logic [3:0]               span_sel_1,
  output logic [3:0]               span_sel_2,
  output logic [3:0]               span_sel_3,
  output logic [3:0]               span_sel_4,
  // Interrupt
  output logic                     irq
);
  import adc_regs_pkg::*;

  bus_state_e       state;
  bus_state_e       next_state;
  logic [7:0]       device_flags;
  logic [7:0]       general_setup;
  logic [7:0]       input_span_ch1_ch2;
  logic [7:0]       input_span_ch3_ch4;
  logic [2:0]       irq_status;
  logic [2:0]       irq_mask;
  logic             wr_pend;
  logic [7:0]       wr_idx;
  logic [7:0]       rd_idx;
  logic             rd_ok;
  logic             wr_ok;

  wire logic        addr_ok;
  wire logic [7:0]  addr_idx;
  wire logic        take;
  wire logic        take_rd;
  wire logic        take_wr;
  wire logic        wr_commit;
  wire logic [7:0]  wdat;
  wire logic [2:0]  flag_src;
  wire logic [2:0]  flag_now;
  wire logic [2:0]  flag_rise;
  wire logic [2:0]  next_irq_status;
  wire logic [31:0] rd_word;
  wire logic [7:0]  next_flags;
  wire logic [7:0]  next_setup;
  wire logic [7:0]  next_span12;
  wire logic [7:0]  next_span34;

  // Address phase decode
  assign addr_idx  = haddr[9:2];
  assign addr_ok   = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0) &&
                     (hsize == HSIZE_WORD);
  assign take      = hsel && hready && (htrans == HTRANS_NSEQ) &&
                     (state != BUS_LOAD);
  assign take_rd   = take && !hwrite;
  assign take_wr   = take && hwrite;
  assign wr_commit = wr_pend && wr_ok;
  assign wdat      = hwdata[7:0];

  // Bus answers, stalled while the enable is low
  assign hreadyout = ce && (state != BUS_LOAD);
  assign hresp     = 1'b0;

  always_comb
  begin
    next_state = state;
    unique case (state)
      BUS_IDLE: if (take_rd) next_state = BUS_LOAD;
      BUS_LOAD: next_state = BUS_OUT;
      BUS_OUT:  next_state = take_rd ? BUS_LOAD : BUS_IDLE;
      default:  next_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state   <= BUS_IDLE;
      wr_pend <= 1'b0;
      wr_ok   <= 1'b0;
      wr_idx  <= 8'h00;
      rd_idx  <= 8'h00;
      rd_ok   <= 1'b0;
    end
    else if (ce)
    begin
      state   <= next_state;
      wr_pend <= take_wr;
      wr_ok   <= take_wr && addr_ok;
      if (take)
      begin
        wr_idx <= addr_idx;
        rd_idx <= addr_idx;
        rd_ok  <= addr_ok;
      end
    end
  end

  // Flags track their sources; no read clears them
  assign flag_src   = {reset_seen, logic_fault_present, open_circuit_present};
  assign flag_now   = {device_flags[FLG_RESET], device_flags[FLG_LOGIC],
                       device_flags[FLG_OPEN]};
  assign next_flags = {flag_src, 5'h00};
  assign flag_rise  = flag_src & ~flag_now;

  // Setup write, read-only bits kept at zero
  assign next_setup = (wr_commit && wr_idx == IDX_SETUP) ?
                      (wdat & SETUP_WMASK) : general_setup;

  // Range fields, undefined codes leave the field unchanged
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_span
      wire logic wr12;
      wire logic wr34;
      assign wr12 = wr_commit && (wr_idx == IDX_SPAN12) &&
                    (wdat[gi*SPAN_W +: SPAN_W] <= SPAN_MAX);
      assign wr34 = wr_commit && (wr_idx == IDX_SPAN34) &&
                    (wdat[gi*SPAN_W +: SPAN_W] <= SPAN_MAX);
      assign next_span12[gi*SPAN_W +: SPAN_W] = wr12 ?
             wdat[gi*SPAN_W +: SPAN_W] :
             input_span_ch1_ch2[gi*SPAN_W +: SPAN_W];
      assign next_span34[gi*SPAN_W +: SPAN_W] = wr34 ?
             wdat[gi*SPAN_W +: SPAN_W] :
             input_span_ch3_ch4[gi*SPAN_W +: SPAN_W];
    end
  endgenerate

  // Sticky events, set wins over write-one clear
  assign next_irq_status = flag_rise |
         (irq_status & ~((wr_commit && wr_idx == IDX_IRQ_STAT) ?
                         wdat[2:0] : 3'h0));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      device_flags       <= FLAGS_RST;
      general_setup      <= SETUP_RST;
      input_span_ch1_ch2 <= SPAN_RST;
      input_span_ch3_ch4 <= SPAN_RST;
      irq_status         <= IRQ_RST;
      irq_mask           <= IRQ_RST;
    end
    else if (ce)
    begin
      device_flags       <= next_flags;
      general_setup      <= next_setup;
      input_span_ch1_ch2 <= next_span12;
      input_span_ch3_ch4 <= next_span34;
      irq_status         <= next_irq_status;
      if (wr_commit && wr_idx == IDX_IRQ_MASK)
        irq_mask <= wdat[2:0];
    end
  end

  // Read mux
  assign rd_word =
    !rd_ok                     ? 32'h0 :
    (rd_idx == IDX_FLAGS)      ? {24'h0, device_flags} :
    (rd_idx == IDX_SETUP)      ? {24'h0, general_setup} :
    (rd_idx == IDX_SPAN12)     ? {24'h0, input_span_ch1_ch2} :
    (rd_idx == IDX_SPAN34)     ? {24'h0, input_span_ch3_ch4} :
    (rd_idx == IDX_IRQ_STAT)   ? {29'h0, irq_status} :
    (rd_idx == IDX_IRQ_MASK)   ? {29'h0, irq_mask} : 32'h0;

  // Outputs from flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata          <= 32'h0;
      irq             <= 1'b0;
      os_conv_trigger <= 1'b0;
    end
    else if (ce)
    begin
      if (state == BUS_LOAD)
        hrdata <= rd_word;
      irq             <= |(irq_status & irq_mask);
      os_conv_trigger <= general_setup[SET_EXT_CLK] ?
                         convert_start_pin : internal_os_clk;
    end
  end

  assign status_header_en          = general_setup[SET_HEADER];
  assign status_header_byte        = device_flags;
  assign outside_oversample_clk_en = general_setup[SET_EXT_CLK];
  assign serial_out_line_sel       =
         general_setup[SET_LINES_HI:SET_LINES_LO];
  assign op_mode = op_mode_e'(general_setup[SET_MODE_HI:SET_MODE_LO]);
  assign span_sel_1 = input_span_ch1_ch2[3:0];
  assign span_sel_2 = input_span_ch1_ch2[7:4];
  assign span_sel_3 = input_span_ch3_ch4[3:0];
  assign span_sel_4 = input_span_ch3_ch4[7:4];

  // Checks
  property p_reset_flag;
    @(posedge hclk) disable iff (!hresetn)
    ce |=> device_flags[FLG_RESET] == $past(reset_seen);
  endproperty
  a_reset_flag: assert property (p_reset_flag)
    else $error("reset flag does not follow source");

  property p_logic_flag;
    @(posedge hclk) disable iff (!hresetn)
    (ce && logic_fault_present) |=> device_flags[FLG_LOGIC];
  endproperty
  a_logic_flag: assert property (p_logic_flag)
    else $error("digital error flag missing");

  property p_open_flag;
    @(posedge hclk) disable iff (!hresetn)
    ce |=> device_flags[FLG_OPEN] == $past(open_circuit_present);
  endproperty
  a_open_flag: assert property (p_open_flag)
    else $error("open input flag does not follow source");

  property p_flags_rsvd;
    @(posedge hclk) disable iff (!hresetn)
    (state == BUS_LOAD && ce && rd_ok && rd_idx == IDX_FLAGS)
      |=> hrdata[4:0] == 5'h00 && hrdata[7:5] == $past(device_flags[7:5]);
  endproperty
  a_flags_rsvd: assert property (p_flags_rsvd)
    else $error("flags read wrong");

  property p_header;
    @(posedge hclk) disable iff (!hresetn)
    (wr_commit && ce && wr_idx == IDX_SETUP)
      |=> status_header_en == $past(hwdata[SET_HEADER]);
  endproperty
  a_header: assert property (p_header)
    else $error("header enable not written");

  property p_ext_clk;
    @(posedge hclk) disable iff (!hresetn)
    (ce && outside_oversample_clk_en)
      |=> os_conv_trigger == $past(convert_start_pin);
  endproperty
  a_ext_clk: assert property (p_ext_clk)
    else $error("trigger not from convert-start pin");

  property p_lines;
    @(posedge hclk) disable iff (!hresetn)
    (wr_commit && ce && wr_idx == IDX_SETUP)
      |=> serial_out_line_sel == $past(hwdata[4:3]) &&
          op_mode == op_mode_e'($past(hwdata[1:0]));
  endproperty
  a_lines: assert property (p_lines)
    else $error("line count or mode not written");

  property p_setup_rsvd;
    @(posedge hclk) disable iff (!hresetn)
    general_setup[7] == 1'b0 && general_setup[2] == 1'b0;
  endproperty
  a_setup_rsvd: assert property (p_setup_rsvd)
    else $error("setup reserved bit set");

  property p_span_legal;
    @(posedge hclk) disable iff (!hresetn)
    span_sel_1 <= SPAN_MAX && span_sel_2 <= SPAN_MAX &&
    span_sel_3 <= SPAN_MAX && span_sel_4 <= SPAN_MAX;
  endproperty
  a_span_legal: assert property (p_span_legal)
    else $error("undefined range code held");

  property p_span_wr;
    @(posedge hclk) disable iff (!hresetn)
    (wr_commit && ce && wr_idx == IDX_SPAN12 && hwdata[7:4] <= SPAN_MAX)
      |=> span_sel_2 == $past(hwdata[7:4]);
  endproperty
  a_span_wr: assert property (p_span_wr)
    else $error("channel 2 range not written");

  property p_span34_wr;
    @(posedge hclk) disable iff (!hresetn)
    (wr_commit && ce && wr_idx == IDX_SPAN34 && hwdata[3:0] <= SPAN_MAX)
      |=> span_sel_3 == $past(hwdata[3:0]) && $stable(span_sel_1);
  endproperty
  a_span34_wr: assert property (p_span34_wr)
    else $error("channel 3 range not written");

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn)
    (take_rd && ce) |=> !hreadyout ##1 (hreadyout || !ce);
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
    ce |=> irq == $past(|(irq_status & irq_mask));
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq level wrong");

  property p_span12_lo;
    @(posedge hclk) disable iff (!hresetn)
    (wr_commit && ce && wr_idx == IDX_SPAN12 && hwdata[3:0] <= SPAN_MAX)
      |=> span_sel_1 == $past(hwdata[3:0]);
  endproperty
  a_span12_lo: assert property (p_span12_lo)
    else $error("channel 1 range not written");

  property p_span34_hi;
    @(posedge hclk) disable iff (!hresetn)
    (wr_commit && ce && wr_idx == IDX_SPAN34 && hwdata[7:4] <= SPAN_MAX)
      |=> span_sel_4 == $past(hwdata[7:4]);
  endproperty
  a_span34_hi: assert property (p_span34_hi)
    else $error("channel 4 range not written");

  property p_span_undef;
    @(posedge hclk) disable iff (!hresetn)
    (wr_commit && ce && wr_idx == IDX_SPAN12 && hwdata[7:4] > SPAN_MAX)
      |=> $stable(span_sel_2);
  endproperty
  a_span_undef: assert property (p_span_undef)
    else $error("undefined range code stored");

  property p_flags_ro;
    @(posedge hclk) disable iff (!hresetn)
    ce |=> device_flags == {$past(reset_seen), $past(logic_fault_present),
                            $past(open_circuit_present), 5'h00};
  endproperty
  a_flags_ro: assert property (p_flags_ro)
    else $error("flags register not a copy of its sources");

  property p_event_set;
    @(posedge hclk) disable iff (!hresetn)
    (ce && reset_seen && !device_flags[FLG_RESET]) |=> irq_status[2];
  endproperty
  a_event_set: assert property (p_event_set)
    else $error("event did not set its status bit");

  property p_ce_freeze;
    @(posedge hclk) disable iff (!hresetn)
    !ce |-> !hreadyout ##1 ($stable(general_setup) && $stable(device_flags) &&
                           $stable(irq_status));
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved while enable low");

  c_read: cover property (@(posedge hclk) disable iff (!hresetn)
    take_rd ##2 hreadyout);
  c_write: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_commit && wr_idx == IDX_SPAN12);
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
  c_ext: cover property (@(posedge hclk) disable iff (!hresetn)
    outside_oversample_clk_en && convert_start_pin);

endmodule // adc_status_config_regs

//--- tb/diag_source_model.sv
// Purpose: Far-side sources: diagnostics and oversampling clocks
// Assumes: Bench sets fault_set and ext_clk_run after a rising edge
// Notes:   Convert-start clock stands low unless ext_clk_run is high
`timescale 1ns/10ps
module diag_source_model
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Bench controls
  input  wire logic [2:0] fault_set,
  input  wire logic       ext_clk_run,
  // Source outputs
  output logic            reset_seen,
  output logic            logic_fault_present,
  output logic            open_circuit_present,
  output logic [7:0]      logic_fault_detail_reg,
  output logic            convert_start_pin,
  output logic            internal_os_clk
);
  logic [1:0] os_div;
  assign internal_os_clk = os_div[1];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {reset_seen, logic_fault_present, open_circuit_present} <= 3'h0;
      logic_fault_detail_reg <= 8'h00;
      convert_start_pin <= 1'b0;
      os_div <= 2'h0;
    end
    else
    begin
      {reset_seen, logic_fault_present, open_circuit_present} <= fault_set;
      logic_fault_detail_reg <= {5'h00, fault_set};
      convert_start_pin <= ext_clk_run & ~convert_start_pin;
      os_div <= os_div + 2'h1;
    end
  end
endmodule // diag_source_model

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the flags, setup and range registers
// Assumes: One wait state on reads, none on writes
// Notes:   Clock enable dropped once to check that the flags freeze
`timescale 1ns/10ps
module tb_top
  import adc_regs_pkg::*;
;
  localparam logic [31:0] addr_flags  = 32'(IDX_FLAGS) << 2;
  localparam logic [31:0] addr_setup  = 32'(IDX_SETUP) << 2;
  localparam logic [31:0] addr_span12 = 32'(IDX_SPAN12) << 2;
  localparam logic [31:0] addr_span34 = 32'(IDX_SPAN34) << 2;
  localparam logic [31:0] addr_istat  = 32'(IDX_IRQ_STAT) << 2;
  localparam logic [31:0] addr_imask  = 32'(IDX_IRQ_MASK) << 2;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        ce = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  fault_set = 3'h0;
  logic        ext_clk_run = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, irq, os_conv_trigger;
  logic        reset_seen, logic_fault_present, open_circuit_present;
  logic        convert_start_pin, internal_os_clk;
  logic        status_header_en, outside_oversample_clk_en;
  logic [7:0]  logic_fault_detail_reg, status_header_byte;
  logic [1:0]  serial_out_line_sel;
  op_mode_e    op_mode;
  logic [3:0]  span_sel_1, span_sel_2, span_sel_3, span_sel_4;
  int          error_cnt = 0;
  int          checked = 0;
  int          cycles = 0;
  always #10 hclk = ~hclk;
  adc_status_config_regs adc_status_config_regs_inst (.hclk(hclk),
    .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .reset_seen(reset_seen),
    .logic_fault_present(logic_fault_present),
    .open_circuit_present(open_circuit_present),
    .logic_fault_detail_reg(logic_fault_detail_reg),
    .convert_start_pin(convert_start_pin),
    .internal_os_clk(internal_os_clk), .os_conv_trigger(os_conv_trigger),
    .status_header_en(status_header_en),
    .status_header_byte(status_header_byte),
    .outside_oversample_clk_en(outside_oversample_clk_en),
    .serial_out_line_sel(serial_out_line_sel), .op_mode(op_mode),
    .span_sel_1(span_sel_1), .span_sel_2(span_sel_2),
    .span_sel_3(span_sel_3), .span_sel_4(span_sel_4), .irq(irq));
  diag_source_model diag_source_model_inst (.hclk(hclk),
    .hresetn(hresetn), .fault_set(fault_set), .ext_clk_run(ext_clk_run),
    .reset_seen(reset_seen), .logic_fault_present(logic_fault_present),
    .open_circuit_present(open_circuit_present),
    .logic_fault_detail_reg(logic_fault_detail_reg),
    .convert_start_pin(convert_start_pin),
    .internal_os_clk(internal_os_clk));
  task automatic complete_run();
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [31:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata);
    hsel <= 1'b1;
    htrans <= HTRANS_NSEQ;
    haddr <= addr;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdata = hrdata;
  endtask
  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    logic [31:0] unused;
    xfer(1'b1, addr, data, unused);
  endtask
  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    xfer(1'b0, addr, 32'h0, got);
    cmp(got, exp);
    cmp(32'(hresp), 32'h0);
  endtask
  task automatic check_trig(input logic ext);
    logic prev;
    @(posedge hclk);
    prev = ext ? convert_start_pin : internal_os_clk;
    repeat (8)
    begin
      @(posedge hclk);
      cmp(32'(os_conv_trigger), 32'(prev));
      prev = ext ? convert_start_pin : internal_os_clk;
    end
  endtask
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(addr_flags, 32'h00);
    rd_chk(addr_setup, 32'h08);
    rd_chk(addr_span12, 32'h33);
    rd_chk(addr_span34, 32'h33);
    rd_chk(addr_istat, 32'h00);
    rd_chk(addr_imask, 32'h00);
    cmp(32'(serial_out_line_sel), 32'h1);
    cmp(32'(op_mode), 32'h0);
    wr(addr_flags, 32'hFF);
    rd_chk(addr_flags, 32'h00);
    wr(32'h14, 32'hFF);
    rd_chk(32'h14, 32'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(addr_setup, 32'(i * 9));
      @(posedge hclk);
      cmp(32'(serial_out_line_sel), 32'(i));
      cmp(32'(op_mode), 32'(i));
    end
    wr(addr_setup, 32'hFF);
    rd_chk(addr_setup, 32'h7B);
    cmp(32'(status_header_en), 32'h1);
    cmp(32'(outside_oversample_clk_en), 32'h1);
    ext_clk_run <= 1'b1;
    check_trig(1'b1);
    ext_clk_run <= 1'b0;
    wr(addr_setup, 32'h00);
    @(posedge hclk);
    cmp(32'(status_header_en), 32'h0);
    check_trig(1'b0);
    wr(addr_span12, 32'h12);
    @(posedge hclk);
    cmp(32'(span_sel_1), 32'h2);
    cmp(32'(span_sel_2), 32'h1);
    wr(addr_span12, 32'hC7);
    rd_chk(addr_span12, 32'h17);
    wr(addr_span34, 32'h9A);
    @(posedge hclk);
    cmp(32'(span_sel_3), 32'hA);
    cmp(32'(span_sel_4), 32'h9);
    wr(addr_span34, 32'hFE);
    rd_chk(addr_span34, 32'h9A);
    for (int c = 0; c < 12; c++)
    begin
      wr(addr_span12, 32'({4'(c), 4'(11 - c)}));
      rd_chk(addr_span12, 32'({4'(c), 4'(11 - c)}));
    end
    fault_set <= 3'h4;
    repeat (3) @(posedge hclk);
    rd_chk(addr_flags, 32'h80);
    rd_chk(addr_flags, 32'h80);
    cmp(32'(status_header_byte), 32'h80);
    rd_chk(addr_istat, 32'h04);
    cmp(32'(irq), 32'h0);
    wr(addr_imask, 32'h04);
    repeat (2) @(posedge hclk);
    cmp(32'(irq), 32'h1);
    wr(addr_istat, 32'h04);
    repeat (2) @(posedge hclk);
    cmp(32'(irq), 32'h0);
    fault_set <= 3'h7;
    repeat (3) @(posedge hclk);
    rd_chk(addr_flags, 32'hE0);
    rd_chk(addr_istat, 32'h03);
    cmp(32'(irq), 32'h0);
    wr(addr_imask, 32'h07);
    repeat (2) @(posedge hclk);
    cmp(32'(irq), 32'h1);
    fault_set <= 3'h0;
    wr(addr_istat, 32'h03);
    repeat (3) @(posedge hclk);
    cmp(32'(irq), 32'h0);
    rd_chk(addr_flags, 32'h00);
    ce <= 1'b0;
    fault_set <= 3'h1;
    repeat (3) @(posedge hclk);
    cmp(32'(status_header_byte), 32'h00);
    fork
      rd_chk(addr_flags, 32'h20);
      begin
        repeat (2) @(posedge hclk);
        ce <= 1'b1;
      end
    join
    rd_chk(addr_istat, 32'h01);
    complete_run();
  end
endmodule // tb_top
